// >>> core/qpp_pkg.sv
// Shared constants and types for the quad page program link
package qpp_pkg;

  // Flash opcodes
  localparam logic [7:0] OP_WR_EN   = 8'h06;
  localparam logic [7:0] OP_QPP     = 8'h32;
  localparam logic [7:0] OP_RDSR_LO = 8'h05;
  localparam logic [7:0] OP_RDSR_HI = 8'h35;

  // Flash status word layout
  localparam int SR_PROG   = 0;
  localparam int SR_LATCH  = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_QUAD   = 9;
  localparam int BP_BITS   = 5;

  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int CLK_MHZ        = 40;
  localparam int PROG_TIME_US   = 500;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
  localparam int SCLK_HALF_NS   = 200;
  localparam int SCLK_HALF_CYC  =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_HIGH_NS     = 100;
  localparam int CS_HIGH_CYC    =
    (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controller register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ADDR    = 8'h04;
  localparam logic [7:0] REG_DATA    = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam logic [7:0] REG_IRQ_ST  = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_IRQ_EN  = 8'h18;

  // Controller field positions
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_GO      = 8;
  localparam int DATA_LAST    = 8;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DREQ    = 1;
  localparam int STAT_RX_LSB  = 8;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_DREQ     = 1;

  typedef enum logic [1:0] {
    QPP_CMD_WR_EN,
    QPP_CMD_PROG,
    QPP_CMD_RDLO,
    QPP_CMD_RDHI
  } qpp_cmd_t;

endpackage : qpp_pkg

// >>> core/qpp_link_if.sv
// Serial link between controller and flash with pulled-up data lines
`timescale 1ns/1ps
interface qpp_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_do;
  logic [3:0] h_oe_n;
  logic [3:0] d_do;
  logic [3:0] d_oe_n;
  logic [3:0] io;

  // Undriven lines float high
  assign io = (h_do | h_oe_n) & (d_do | d_oe_n);

  modport host  (output cs_n, sclk, h_do, h_oe_n, input io);
  modport flash (input cs_n, sclk, io, output d_do, d_oe_n);
endinterface : qpp_link_if

// >>> core/qpp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module qpp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '1;
      q_o    <= '1;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : qpp_sync

// >>> core/qpp_flash.sv
// Flash end: quad page program command handler
// Overview of operation
// - Quad program needs status quad enable bit 9
// - Quad program needs write enable latch set
// - Host sends select, opcode 32h, address, data
// - Over 256 bytes keeps only last 256
// - Short bursts leave other page bytes alone
// - Select rising mid-byte abandons the command
// - Program cycle starts when select rises
// - Write in progress high throughout program cycle
// - Status reads still answered while programming
// - Write enable latch cleared before cycle end
// - Protected pages ignore the quad program
// - Data past page end wraps to start
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module qpp_flash
  import qpp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Serial link
  qpp_link_if.flash         link,
  // Non-volatile status bits
  input  wire logic         quad_enable_flag_i,
  input  wire logic [4:0]   block_protect_i,
  // Status view
  output logic              write_enable_latch_o,
  output logic              write_in_progress_flag_o,
  // Array write port
  output logic              mem_we_o,
  output logic [23:0]       mem_addr_o,
  output logic [7:0]        mem_data_o
);

  typedef enum logic [2:0] {
    D_OP, D_WR_EN, D_RDSR, D_ADDR, D_DATA, D_IGN
  } qpp_dst_t;

  // Top or bottom fraction of the 16 blocks, by the low protect bits
  function automatic logic qpp_protected(input logic [4:0] bp,
                                         input logic [3:0] blk);
    logic [4:0] n;
    logic       hit;
    n   = 5'h01 << (bp[2:0] - 3'h1);
    hit = bp[3] ? ({1'b0, blk} < n) : ({1'b0, blk} >= (5'h10 - n));
    if (bp[2:0] == 3'h0)
      return 1'b0;
    else if (bp[2:0] >= 3'h5)
      return 1'b1;
    else
      return hit;
  endfunction : qpp_protected

  logic [5:0]   pin_s;
  logic         cs_d_q;
  logic         sclk_d_q;
  qpp_dst_t     st_q;
  logic [2:0]   bcnt_q;
  logic [7:0]   sh_q;
  logic [1:0]   abyte_q;
  logic [23:0]  addr_q;
  logic [7:0]   col_q;
  logic         got_q;
  logic         hi_q;
  logic [7:0]   out_q;
  logic [2:0]   ocnt_q;
  logic         so_q;
  logic [255:0] valid_q;
  logic [7:0]   buf_q [256];
  logic         busy_q;
  logic         wel_q;
  logic [31:0]  tmr_q;
  logic [8:0]   pidx_q;

  qpp_sync #(.W(6)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.cs_n, link.sclk, link.io}),
    .q_o   (pin_s)
  );

  wire        cs_n_s   = pin_s[5];
  wire        sclk_s   = pin_s[4];
  wire [3:0]  io_s     = pin_s[3:0];
  wire        rise     = sclk_s & ~sclk_d_q & ~cs_n_s;
  wire        fall     = ~sclk_s & sclk_d_q & ~cs_n_s;
  wire        cs_up    = cs_n_s & ~cs_d_q;
  wire [7:0]  op_byte  = {sh_q[6:0], io_s[0]};
  wire [7:0]  nib_byte = {sh_q[3:0], io_s};
  wire        op_done  = rise && st_q == D_OP && bcnt_q == 3'h7;
  wire        is_rdsr  = op_byte == OP_RDSR_LO || op_byte == OP_RDSR_HI;
  wire        qpp_ok   = op_byte == OP_QPP && !busy_q &&
                         quad_enable_flag_i && wel_q;
  wire        byte_in  = rise && bcnt_q[0];
  wire        byte_wr  = byte_in && st_q == D_DATA;
  wire        last_ab  = byte_in && st_q == D_ADDR && abyte_q == 2'h2;
  wire [23:0] addr_nx  = {addr_q[15:0], nib_byte};
  wire        prot     = qpp_protected(block_protect_i, addr_nx[19:16]);
  // Only a select rise on a whole data byte launches programming
  wire        start_pr = cs_up && st_q == D_DATA && got_q &&
                         !bcnt_q[0];
  wire        wen_end  = cs_up && st_q == D_WR_EN;

  logic [15:0] stat_w;
  always_comb
  begin
    stat_w                          = '0;
    stat_w[SR_PROG]                 = busy_q;
    stat_w[SR_LATCH]                = wel_q;
    stat_w[SR_BP_LSB +: BP_BITS]    = block_protect_i;
    stat_w[SR_QUAD]                 = quad_enable_flag_i;
  end

  wire [7:0] stat_lo = stat_w[7:0];
  wire [7:0] stat_hi = stat_w[15:8];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cs_d_q   <= 1'b1;
      sclk_d_q <= 1'b1;
    end
    else
    begin
      cs_d_q   <= cs_n_s;
      sclk_d_q <= sclk_s;
    end
  end

  // Command decode, address and data capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_n_s)
    begin
      st_q    <= D_OP;
      bcnt_q  <= 3'h0;
      sh_q    <= 8'h00;
      abyte_q <= 2'h0;
      got_q   <= 1'b0;
      if (rst_i)
      begin
        addr_q <= 24'h00_0000;
        col_q  <= 8'h00;
        hi_q   <= 1'b0;
      end
    end
    else if (rise)
    begin
      unique case (st_q)
        D_OP:
        begin
          sh_q   <= op_byte;
          bcnt_q <= bcnt_q + 3'h1;
          if (bcnt_q == 3'h7)
          begin
            hi_q <= op_byte == OP_RDSR_HI;
            if (is_rdsr)
              st_q <= D_RDSR;
            else if (op_byte == OP_WR_EN && !busy_q)
              st_q <= D_WR_EN;
            else if (qpp_ok)
              st_q <= D_ADDR;
            else
              st_q <= D_IGN;
          end
        end
        D_WR_EN:
          st_q <= D_IGN;
        D_ADDR:
        begin
          sh_q   <= nib_byte;
          bcnt_q <= {2'b00, ~bcnt_q[0]};
          if (bcnt_q[0])
          begin
            addr_q  <= addr_nx;
            abyte_q <= abyte_q + 2'h1;
            if (abyte_q == 2'h2)
            begin
              col_q <= addr_nx[7:0];
              st_q  <= prot ? D_IGN : D_DATA;
            end
          end
        end
        D_DATA:
        begin
          sh_q   <= nib_byte;
          bcnt_q <= {2'b00, ~bcnt_q[0]};
          if (bcnt_q[0])
          begin
            col_q <= col_q + 8'h01;
            got_q <= 1'b1;
          end
        end
        D_RDSR, D_IGN:
          bcnt_q <= bcnt_q;
      endcase
    end
  end

  // Status byte shifted out on the falling edge, refreshed per byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_q  <= 8'h00;
      ocnt_q <= 3'h0;
      so_q   <= 1'b0;
    end
    else if (op_done)
    begin
      out_q  <= (op_byte == OP_RDSR_HI) ? stat_hi : stat_lo;
      ocnt_q <= 3'h0;
    end
    else if (fall && st_q == D_RDSR)
    begin
      so_q   <= out_q[7];
      ocnt_q <= ocnt_q + 3'h1;
      if (ocnt_q == 3'h7)
        out_q <= hi_q ? stat_hi : stat_lo;
      else
        out_q <= {out_q[6:0], 1'b0};
    end
  end

  // Page buffer: later bytes overwrite earlier ones at the same column
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      valid_q <= '0;
    else if (last_ab)
      valid_q <= '0;
    else if (byte_wr)
      valid_q[col_q] <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (byte_wr)
      buf_q[col_q] <= nib_byte;
  end

  // Self-timed program cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_q     <= 1'b0;
      wel_q      <= 1'b0;
      tmr_q      <= 32'h0000_0000;
      pidx_q     <= 9'h000;
      mem_we_o   <= 1'b0;
      mem_addr_o <= 24'h00_0000;
      mem_data_o <= 8'h00;
    end
    else
    begin
      mem_we_o <= 1'b0;
      if (busy_q)
      begin
        tmr_q <= tmr_q + 32'h0000_0001;
        if (!pidx_q[8])
        begin
          mem_we_o   <= valid_q[pidx_q[7:0]];
          mem_addr_o <= {addr_q[23:8], pidx_q[7:0]};
          mem_data_o <= buf_q[pidx_q[7:0]];
          pidx_q     <= pidx_q + 9'h001;
        end
        if (tmr_q == PROG_CYCLES - 1)
          busy_q <= 1'b0;
      end
      else if (start_pr)
      begin
        busy_q <= 1'b1;
        wel_q  <= 1'b0;
        tmr_q  <= 32'h0000_0000;
        pidx_q <= 9'h000;
      end
      else if (wen_end)
        wel_q <= 1'b1;
    end
  end

  assign link.d_do   = {2'b11, so_q, 1'b1};
  assign link.d_oe_n = {2'b11, st_q != D_RDSR, 1'b1};

  assign write_enable_latch_o     = wel_q;
  assign write_in_progress_flag_o = busy_q;

endmodule : qpp_flash

// >>> core/qpp_ctrl.sv
// Controller end: Wishbone slave that drives the quad flash link
`timescale 1ns/1ps
module qpp_ctrl
  import qpp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq_o,
  // Serial link
  qpp_link_if.host         link
);

  typedef enum logic [2:0] {
    H_IDLE, H_XFER, H_NEXT, H_WAITD, H_STOP
  } qpp_hst_t;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] qpp_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : qpp_merge

  qpp_hst_t    st_q;
  qpp_cmd_t    cmd_q;
  logic [23:0] addr_q;
  logic [7:0]  dat_q;
  logic        dlast_q;
  logic        dpend_q;
  logic [7:0]  rxs_q;
  logic [7:0]  rx_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_en_q;
  logic [3:0]  div_q;
  logic        sclk_q;
  logic        csn_q;
  logic [7:0]  sh_q;
  logic [3:0]  nclk_q;
  logic [2:0]  bidx_q;
  logic        quad_q;
  logic        rd_q;
  logic        last_q;
  logic [3:0]  oe_n_q;
  logic        io1_s;

  qpp_sync #(.W(1)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (link.io[1]),
    .q_o   (io1_s)
  );

  wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge where the master sees ack
  wire        wr      = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  wire        wr_ctrl = wr && wb_adr_i == REG_CTRL;
  wire        wr_data = wr && wb_adr_i == REG_DATA && wb_sel_i[0];
  wire [31:0] ctrl_m  = qpp_merge({23'h0, 1'b0, 6'h0, cmd_q}, wb_dat_i,
                                  wb_sel_i);
  wire [31:0] data_m  = qpp_merge({23'h0, dlast_q, dat_q}, wb_dat_i,
                                  wb_sel_i);
  wire [31:0] addr_m  = qpp_merge({8'h00, addr_q}, wb_dat_i, wb_sel_i);
  wire [31:0] ien_m   = qpp_merge({30'h0, irq_en_q}, wb_dat_i, wb_sel_i);
  wire        go      = wr_ctrl && ctrl_m[CTRL_GO] && st_q == H_IDLE;
  wire [1:0]  go_cmd  = ctrl_m[CTRL_CMD_LSB +: 2];
  wire        tick    = div_q == 4'(SCLK_HALF_CYC - 1);
  wire [3:0]  per_byt = quad_q ? 4'h2 : 4'h8;
  wire        take_d  = st_q == H_WAITD && dpend_q;
  wire        ev_done = st_q == H_STOP && tick;
  wire        ev_dreq = st_q == H_NEXT && cmd_q == QPP_CMD_PROG &&
                        bidx_q >= 3'h2 && !last_q;
  wire [1:0]  ev      = {ev_dreq, ev_done};
  wire [1:0]  clr     = (wr && wb_adr_i == REG_IRQ_CLR && wb_sel_i[0]) ?
                        wb_dat_i[1:0] : 2'b00;
  wire [7:0]  abyte   = (bidx_q == 3'h0) ? addr_q[23:16] :
                        (bidx_q == 3'h1) ? addr_q[15:8] : addr_q[7:0];

  logic [7:0] opc;
  always_comb
  begin
    unique case (qpp_cmd_t'(go_cmd))
      QPP_CMD_WR_EN: opc = OP_WR_EN;
      QPP_CMD_PROG: opc = OP_QPP;
      QPP_CMD_RDLO: opc = OP_RDSR_LO;
      QPP_CMD_RDHI: opc = OP_RDSR_HI;
    endcase
  end

  // Register file and bus answer, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      cmd_q    <= QPP_CMD_WR_EN;
      addr_q   <= 24'h00_0000;
      dat_q    <= 8'h00;
      dlast_q  <= 1'b0;
      dpend_q  <= 1'b0;
      irq_st_q <= 2'b00;
      irq_en_q <= 2'b00;
    end
    else
    begin
      wb_ack_o <= req;
      if (wr_ctrl && st_q == H_IDLE)
        cmd_q <= qpp_cmd_t'(go_cmd);
      if (wr && wb_adr_i == REG_ADDR)
        addr_q <= addr_m[23:0];
      if (wr && wb_adr_i == REG_IRQ_EN)
        irq_en_q <= ien_m[1:0];
      if (wr_data)
      begin
        dat_q   <= data_m[7:0];
        dlast_q <= data_m[DATA_LAST];
      end
      dpend_q  <= wr_data | (dpend_q & ~take_d);
      irq_st_q <= (irq_st_q & ~clr) | ev;
    end
  end

  always_comb
  begin
    wb_dat_o = 32'h0000_0000;
    unique case (wb_adr_i)
      REG_CTRL:   wb_dat_o[1:0] = cmd_q;
      REG_ADDR:   wb_dat_o[23:0] = addr_q;
      REG_DATA:   wb_dat_o[DATA_LAST:0] = {dpend_q, dat_q};
      REG_STATUS:
      begin
        wb_dat_o[STAT_BUSY]          = st_q != H_IDLE;
        wb_dat_o[STAT_DREQ]          = st_q == H_WAITD && !dpend_q;
        wb_dat_o[STAT_RX_LSB +: 8]   = rxs_q;
      end
      REG_IRQ_ST: wb_dat_o[1:0] = irq_st_q;
      REG_IRQ_EN: wb_dat_o[1:0] = irq_en_q;
      default:    wb_dat_o = 32'h0000_0000;
    endcase
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  // Link sequencer, mode 0 clock made by dividing clk_i
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= H_IDLE;
      div_q  <= 4'h0;
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      sh_q   <= 8'h00;
      nclk_q <= 4'h0;
      bidx_q <= 3'h0;
      quad_q <= 1'b0;
      rd_q   <= 1'b0;
      last_q <= 1'b0;
      oe_n_q <= 4'hF;
      rx_q   <= 8'h00;
      rxs_q  <= 8'h00;
    end
    else
    begin
      unique case (st_q)
        H_IDLE:
          if (go)
          begin
            csn_q  <= 1'b0;
            sh_q   <= opc;
            quad_q <= 1'b0;
            rd_q   <= 1'b0;
            last_q <= 1'b0;
            bidx_q <= 3'h0;
            nclk_q <= 4'h0;
            div_q  <= 4'h0;
            oe_n_q <= 4'hE;
            st_q   <= H_XFER;
          end
        H_XFER:
        begin
          div_q <= tick ? 4'h0 : div_q + 4'h1;
          if (tick && !sclk_q)
          begin
            sclk_q <= 1'b1;
            nclk_q <= nclk_q + 4'h1;
            rx_q   <= {rx_q[6:0], io1_s};
          end
          else if (tick)
          begin
            sclk_q <= 1'b0;
            if (nclk_q == per_byt)
              st_q <= H_NEXT;
            else
              sh_q <= quad_q ? {sh_q[3:0], 4'hF} : {sh_q[6:0], 1'b1};
          end
        end
        H_NEXT:
        begin
          nclk_q <= 4'h0;
          div_q  <= 4'h0;
          if (st_q == H_NEXT && bidx_q != 3'h7)
            bidx_q <= bidx_q + 3'h1;
          if (cmd_q == QPP_CMD_WR_EN || rd_q ||
              (cmd_q == QPP_CMD_PROG && last_q))
          begin
            if (rd_q)
              rxs_q <= rx_q;
            csn_q  <= 1'b1;
            oe_n_q <= 4'hF;
            st_q   <= H_STOP;
          end
          else if (cmd_q != QPP_CMD_PROG)
          begin
            rd_q   <= 1'b1;
            oe_n_q <= 4'hF;
            st_q   <= H_XFER;
          end
          else if (bidx_q < 3'h3)
          begin
            sh_q   <= abyte;
            quad_q <= 1'b1;
            oe_n_q <= 4'h0;
            st_q   <= H_XFER;
          end
          else
            st_q <= H_WAITD;
        end
        H_WAITD:
          if (dpend_q)
          begin
            sh_q   <= dat_q;
            last_q <= dlast_q;
            st_q   <= H_XFER;
          end
        H_STOP:
        begin
          div_q <= tick ? 4'h0 : div_q + 4'h1;
          if (tick)
            st_q <= H_IDLE;
        end
        default:
          st_q <= H_IDLE;
      endcase
    end
  end

  assign link.cs_n   = csn_q;
  assign link.sclk   = sclk_q;
  assign link.h_do   = quad_q ? sh_q[7:4] : {3'b111, sh_q[7]};
  assign link.h_oe_n = oe_n_q;

endmodule : qpp_ctrl

// >>> tb/qpp_link_properties.sv
// Concurrent checks on the link and the flash status outputs
`timescale 1ns/1ps
module qpp_link_properties #(
  parameter int unsigned PROG_CYCLES = 20000
) (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] h_oe_n,
  input wire logic [3:0] d_oe_n,
  // Flash side
  input wire logic       quad_enable_flag_i,
  input wire logic       write_enable_latch_o,
  input wire logic       write_in_progress_flag_o,
  input wire logic       mem_we_o
);
  localparam int LO = PROG_CYCLES - 2;
  localparam int HI = PROG_CYCLES + 2;
  int busy_q;

  // Length of the current write-in-progress run
  always_ff @(posedge clk_i)
    if (rst_i || !write_in_progress_flag_o)
      busy_q <= 0;
    else
      busy_q <= busy_q + 1;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock moved outside a frame");
  property p_sclk_half;
    $rose(sclk) |-> sclk [*8] ##1 !sclk;
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock high phase not eight cycles");
  property p_need_qe;
    $rose(write_in_progress_flag_o) |-> quad_enable_flag_i;
  endproperty
  a_need_qe: assert property (p_need_qe)
    else $error("program started with quad mode off");
  property p_need_wel;
    $rose(write_in_progress_flag_o) |-> $past(write_enable_latch_o);
  endproperty
  a_need_wel: assert property (p_need_wel)
    else $error("program started without write enable latch");
  property p_start;
    $rose(write_in_progress_flag_o) |-> cs_n && $past(cs_n);
  endproperty
  a_start: assert property (p_start)
    else $error("program started while selected");
  property p_wel_gone;
    $fell(write_in_progress_flag_o) |-> !write_enable_latch_o;
  endproperty
  a_wel_gone: assert property (p_wel_gone)
    else $error("write enable latch still set at cycle end");
  property p_len;
    $fell(write_in_progress_flag_o) |-> busy_q >= LO && busy_q <= HI;
  endproperty
  a_len: assert property (p_len)
    else $error("program cycle length wrong");
  property p_we_in_cycle;
    mem_we_o |-> write_in_progress_flag_o;
  endproperty
  a_we_in_cycle: assert property (p_we_in_cycle)
    else $error("array written outside program cycle");
  property p_status_drv;
    !d_oe_n[1] |-> !$past(cs_n, 3) && h_oe_n[1];
  endproperty
  a_status_drv: assert property (p_status_drv)
    else $error("flash drives line outside frame or against host");

  c_prog: cover property ($rose(write_in_progress_flag_o));
  c_done: cover property ($fell(write_in_progress_flag_o));
  c_stat: cover property (!d_oe_n[1] && write_in_progress_flag_o);
  c_we: cover property (mem_we_o);
endmodule : qpp_link_properties

// >>> tb/test_quad_page_program.sv
// Self-checking bench for controller and flash joined by the link
`timescale 1ns/1ps
module test_quad_page_program;
  import qpp_pkg::*;
  localparam int unsigned PC = 2000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        qe = 1'b1;
  logic [4:0]  bp = 5'h00;
  logic        write_enable_latch;
  logic        write_in_progress_flag;
  logic        mem_we;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  logic [7:0]  got [int];
  logic [7:0]  op_sh;
  logic [7:0]  last_op;
  logic [31:0] r;
  int          n_we;
  int          nrise;
  int          n_fail = 0;
  int          num_checks = 0;
  int          seed = 32524;

  qpp_link_if i_qpp_link_if ();
  qpp_ctrl i_qpp_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .link(i_qpp_link_if.host));
  qpp_flash #(.PROG_CYCLES(PC)) i_qpp_flash (.clk_i(clk_i),
    .rst_i(rst_i), .link(i_qpp_link_if.flash), .quad_enable_flag_i(qe),
    .block_protect_i(bp), .write_enable_latch_o(write_enable_latch),
    .write_in_progress_flag_o(write_in_progress_flag), .mem_we_o(mem_we),
    .mem_addr_o(mem_addr), .mem_data_o(mem_data));
  qpp_link_properties #(.PROG_CYCLES(PC)) i_qpp_link_properties (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n(i_qpp_link_if.cs_n),
    .sclk(i_qpp_link_if.sclk), .h_oe_n(i_qpp_link_if.h_oe_n),
    .d_oe_n(i_qpp_link_if.d_oe_n), .quad_enable_flag_i(qe),
    .write_enable_latch_o(write_enable_latch), .write_in_progress_flag_o(write_in_progress_flag),
    .mem_we_o(mem_we));

  initial
    forever #12.5 clk_i = ~clk_i;

  // Array writes seen during program cycles
  always @(posedge clk_i)
    if (mem_we === 1'b1)
    begin
      got[mem_addr] = mem_data;
      n_we++;
    end

  // Opcode shifted in on data line 0 at the first eight rises
  always @(negedge i_qpp_link_if.cs_n)
    nrise = 0;
  always @(posedge i_qpp_link_if.sclk)
  begin
    if (nrise < 8)
      op_sh = {op_sh[6:0], i_qpp_link_if.io[0]};
    nrise++;
    if (nrise == 8)
      last_op = op_sh;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic int n_expected(input int n, input logic ok);
    return ok ? ((n > 256) ? 256 : n) : 0;
  endfunction : n_expected

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wait_idle();
    do wb(1'b0, REG_STATUS, 32'h0, r); while (r[STAT_BUSY] !== 1'b0);
  endtask : wait_idle

  task automatic cmd(input qpp_cmd_t c);
    wb(1'b1, REG_CTRL, 32'h0000_0100 | 32'(c), r);
    wait_idle();
  endtask : cmd

  task automatic stat(output logic [7:0] s);
    cmd(QPP_CMD_RDLO);
    wb(1'b0, REG_STATUS, 32'h0, r);
    s = r[15:8];
  endtask : stat

  task automatic run_case(input logic q, input logic [4:0] b,
    input logic wr_en, input logic [23:0] a, input int n, input logic ok);
    logic [7:0] exp [int];
    logic [7:0] st;
    logic [7:0] d;
    int lim;
    got.delete();
    n_we = 0;
    lim = 0;
    @(posedge clk_i);
    qe <= q;
    bp <= b;
    if (wr_en)
      cmd(QPP_CMD_WR_EN);
    stat(st);
    chk("latch after enable", wr_en, st[SR_LATCH]);
    wb(1'b1, REG_ADDR, {8'h00, a}, r);
    wb(1'b1, REG_CTRL, 32'h0000_0100 | 32'(QPP_CMD_PROG), r);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      do wb(1'b0, REG_STATUS, 32'h0, r); while (r[STAT_DREQ] !== 1'b1);
      exp[{a[23:8], a[7:0] + i[7:0]}] = d;
      wb(1'b1, REG_DATA, {23'h0, i == n - 1, d}, r);
    end
    wait_idle();
    chk("opcode", {24'h0, OP_QPP}, {24'h0, last_op});
    stat(st);
    chk("busy flag", ok, st[SR_PROG]);
    if (ok)
      chk("latch in cycle", 0, st[SR_LATCH]);
    while (st[SR_PROG] === 1'b1 && lim < 40)
    begin
      stat(st);
      lim++;
    end
    chk("busy flag end", 0, st[SR_PROG]);
    chk("writes", n_expected(n, ok), n_we);
    if (ok)
      foreach (exp[k])
        chk("byte", exp[k], got.exists(k) ? got[k] : 8'hxx);
    $display("case at %h length %0d done", a, n);
  endtask : run_case

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #2_000_000;
    n_fail++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    r = $random(seed);
    run_case(1'b1, 5'h00, 1'b1, {r[23:8], 8'hF0}, 20, 1'b1);
    // Done event seen while masked, then unmasked and cleared
    chk("irq masked", 0, irq);
    wb(1'b0, REG_IRQ_ST, 32'h0, r);
    chk("irq status", 1, r[IRQ_DONE]);
    wb(1'b1, REG_IRQ_EN, 32'h0000_0001, r);
    repeat (2) @(posedge clk_i);
    chk("irq raised", 1, irq);
    wb(1'b1, REG_IRQ_CLR, 32'h0000_0003, r);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 0, irq);
    wb(1'b0, 8'h1C, 32'h0, r);
    chk("unmapped", 0, r);
    cmd(QPP_CMD_RDHI);
    wb(1'b0, REG_STATUS, 32'h0, r);
    chk("quad flag", 1, r[STAT_RX_LSB + SR_QUAD - 8]);
    $display("interrupt and status test done");
    r = $random(seed);
    run_case(1'b1, 5'h00, 1'b1, {r[23:8], 8'h00}, 258, 1'b1);
    run_case(1'b1, 5'h00, 1'b0, r[23:0], 3, 1'b0);
    run_case(1'b0, 5'h00, 1'b1, r[23:0], 3, 1'b0);
    run_case(1'b1, 5'h01, 1'b1, {8'h0F, r[15:0]}, 2, 1'b0);
    run_case(1'b1, 5'h01, 1'b1, {8'h00, r[15:0]}, 1, 1'b1);
    end_sim();
  end
endmodule : test_quad_page_program
